// [sim/serial_pin_mux_sva.sv]
/* checker for the serial pin function mux.
   assumes binding to the mux top; one clock, async active-high reset. */
`timescale 1ns/1ps
module serial_pin_mux_sva
    import serial_pin_mux_pkg::*;
(
    input wire logic             clk,                   // clock
    input wire logic             reset,                 // reset
    input wire logic             function_group_select, // group
    input wire pin_function_type tx_function,           // pin one
    input wire pin_function_type rx_function,           // pin two
    input wire pin_function_type rts_function,          // pin three
    input wire logic             uart_tx_data,          // uart out
    input wire logic             uart_rts,              // rts
    input wire logic             tap_data_out,          // tap out
    input wire logic             tap_shift_state,       // shifting
    input wire logic [2:0]       pin_in,                // pads in
    input wire logic [2:0]       pin_out,               // pads out
    input wire logic [2:0]       pin_oe_n,              // pad enables
    input wire logic             uart_rx_data,          // uart in
    input wire logic             second_capture_input,  // capture two
    input wire logic             tap_data_in,           // tap in
    input wire logic             tap_data_out_pin_oe_n, // dedicated out
    input wire logic             internal_reset         // reset request
);
    logic       nrm;
    logic       alt;
    logic [2:0] lo_cnt;
    // ====================
    // previous group, low run
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            {nrm, alt, lo_cnt} <= 5'h00;
        end else begin
            nrm    <= !function_group_select;
            alt    <= function_group_select;
            lo_cnt <= (function_group_select && !pin_in[2]) ? lo_cnt + {2'h0, lo_cnt != 3'h7} : 3'h0;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_tx_uart_drive: assert property (nrm && $past(tx_function) == fn_uart
        |-> pin_oe_n[0] == PIN_DRIVE && pin_out[0] == $past(uart_tx_data)) else $error("tx pin");
    a_tdo_shift_only: assert property (alt |-> pin_oe_n[0] == !$past(tap_shift_state)
        && (pin_oe_n[0] || pin_out[0] == $past(tap_data_out))) else $error("tdo pin");
    a_alt_tap_route: assert property (alt |-> tap_data_out_pin_oe_n == PIN_RELEASE
        && tap_data_in == $past(pin_in[1]) && pin_oe_n[2:1] == 2'h3) else $error("alt route");
    a_rx_feed: assert property (nrm && $past(rx_function) == fn_uart
        |-> uart_rx_data == $past(pin_in[1]) && pin_oe_n[1] == PIN_RELEASE) else $error("rx");
    a_rts_drive: assert property (nrm && $past(rts_function) == fn_uart
        |-> pin_oe_n[2] == PIN_DRIVE && pin_out[2] == $past(uart_rts)) else $error("rts");
    a_capture_two: assert property (nrm && $past(rts_function) == fn_capture
        |-> second_capture_input == $past(pin_in[2])) else $error("capture two");
    a_reset_long: assert property ($rose(internal_reset) && alt |-> lo_cnt >= 3'h5) else $error("short");
    a_reset_inputs: assert property (disable iff (1'b0) reset
        |-> pin_oe_n == 3'h7 && !internal_reset) else $error("reset state");
endmodule
bind serial_port_pin_function_mux serial_pin_mux_sva i_sva (.*);

// [sim/serial_side_model.sv]
/* side model: uart, tap and reference clock sources for the pin mux.
   assumes the bench clock and its async active-high reset. */
`timescale 1ns/1ps
module serial_side_model (
    input  wire logic clk,                      // clock
    input  wire logic reset,                    // reset
    input  wire logic shift_en,                 // tap shift request
    output logic      uart_tx_data,             // uart out
    output logic      uart_rts,                 // rts
    output logic      tap_data_out,             // tap out
    output logic      tap_shift_state,          // tap shifting
    output logic      low_freq_reference_clock  // reference
);
    logic [2:0] div;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div             <= 3'h0;
            tap_shift_state <= 1'b0;
        end else begin
            div             <= div + 3'h1;
            tap_shift_state <= shift_en;
        end
    end
    assign uart_tx_data = div[0];
    assign uart_rts = div[1];
    assign tap_data_out = ~div[0];
    assign low_freq_reference_clock = div[2];
endmodule

// [sim/testbench.sv]
/* bench for the serial pin function mux.
   assumes the side model drives uart, tap and reference inputs. */
`timescale 1ns/1ps
module testbench;
    import serial_pin_mux_pkg::*;
    typedef struct packed {logic g; pin_function_type t, r, s; logic [2:0] d, p; logic sh; logic [7:0] e;} row_type;
    logic clk, reset, function_group_select, shift_en, uart_tx_data, uart_rx_data, uart_rts, q_tx, q_tdo;
    logic autobaud_capture_input, second_capture_input, tap_data_out, tap_shift_state, tap_data_in;
    logic tap_data_out_pin, tap_data_out_pin_oe_n, tap_data_in_pin, reset_in_pin_n;
    logic low_freq_reference_clock, internal_reset, exp_p0;
    logic [2:0] gpio_out, gpio_dir, gpio_in, pin_in, pin_out, pin_oe_n;
    pin_function_type tx_function, rx_function, rts_function;
    int mismatches, n_compared, cycles;
    row_type rows [5];
    serial_port_pin_function_mux i_dut (.*);
    serial_side_model i_side (.*);
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // one cycle after a reference rise, pull pin three low for n cycles
    task automatic hold_low(input int n);
        @(posedge low_freq_reference_clock);
        @(posedge clk);
        pin_in[2] <= 1'b0;
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        q_tx <= uart_tx_data;
        q_tdo <= tap_data_out;
        cycles++;
        if (cycles == 1000) begin
            mismatches++;
            final_report;
        end
    end
    initial begin
        {reset, reset_in_pin_n, gpio_out, gpio_dir, pin_in} = {2'h3, 3'h5, 3'h0, 3'h4};
        {function_group_select, shift_en, tap_data_in_pin} = 3'h0;
        {tx_function, rx_function, rts_function} = {fn_gpio, fn_gpio, fn_gpio};
        rows = '{'{1'b0, fn_uart, fn_uart, fn_uart, 3'h0, 3'h0, 1'b1, 8'h4C},
                 '{1'b0, fn_capture, fn_capture, fn_capture, 3'h1, 3'h4, 1'b0, 8'hD5},
                 '{1'b0, fn_gpio, fn_gpio, fn_gpio, 3'h6, 3'h0, 1'b1, 8'h3C},
                 '{1'b1, fn_uart, fn_uart, fn_uart, 3'h7, 3'h6, 1'b1, 8'hDF},
                 '{1'b1, fn_gpio, fn_gpio, fn_gpio, 3'h0, 3'h4, 1'b0, 8'hFD}};
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            @(posedge clk);
            {function_group_select, gpio_dir, pin_in, shift_en} <= {rows[i].g, rows[i].d, rows[i].p, rows[i].sh};
            tx_function <= rows[i].t;
            rx_function <= rows[i].r;
            rts_function <= rows[i].s;
            settle(2);
            chk({pin_oe_n, uart_rx_data, autobaud_capture_input, second_capture_input, tap_data_in,
                 tap_data_out_pin_oe_n}, rows[i].e);
            chk({5'h0, gpio_in}, {5'h0, rows[i].p});
            exp_p0 = rows[i].g ? q_tdo : ((rows[i].t == fn_uart) ? q_tx : gpio_out[0]);
            if (!rows[i].e[5]) chk({7'h0, pin_out[0]}, {7'h0, exp_p0});
            chk({7'h0, tap_data_out_pin}, {7'h0, q_tdo});
        end
        $display("table rows done");
        @(posedge clk);
        {reset, function_group_select, gpio_dir} <= {2'h2, 3'h0};
        {tx_function, rx_function, rts_function} <= {fn_gpio, fn_gpio, fn_gpio};
        @(negedge clk);
        chk({pin_oe_n, internal_reset, gpio_in, 1'b0}, 8'hE0);
        @(posedge clk);
        reset <= 1'b0;
        settle(2);
        chk({5'h0, pin_oe_n}, 8'h07);
        $display("reset test done");
        @(posedge clk);
        {function_group_select, reset_in_pin_n} <= 2'h2;
        hold_low(20);
        chk({7'h0, internal_reset}, 8'h00);
        @(posedge clk);
        pin_in[2] <= 1'b1;
        repeat (4) @(posedge clk);
        hold_low(30);
        chk({7'h0, internal_reset}, 8'h01);
        @(posedge clk);
        pin_in[2] <= 1'b1;
        settle(3);
        chk({7'h0, internal_reset}, 8'h00);
        @(posedge clk);
        function_group_select <= 1'b0;
        settle(2);
        chk({7'h0, internal_reset}, 8'h01);
        $display("alternate reset test done");
        final_report;
    end
endmodule

// [verilog/ref_low_counter.sv]
/*
 * counts reference clock edges while a low-active request is held low.
 * assumes the reference clock and request are synchronous to clk.
 */
`timescale 1ns/1ps
module ref_low_counter #(
    parameter int CYCLES = serial_pin_mux_pkg::RESET_REF_CYCLES
) (
    input  wire logic clk,        // system clock
    input  wire logic reset,      // async reset, active high
    input  wire logic enable,     // count only while enabled
    input  wire logic request_n,  // low-active request level
    input  wire logic ref_clock,  // reference clock level
    output logic      accepted    // request held long enough
);
    import serial_pin_mux_pkg::*;

    logic [REF_COUNT_WIDTH-1:0] count;
    logic                       ref_last;
    wire                        ref_rise = ref_clock & ~ref_last;
    wire                        held     = enable & ~request_n;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ref_last <= 1'b0;
        end else begin
            ref_last <= ref_clock;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count    <= REF_COUNT_ZERO;
            accepted <= 1'b0;
        end else if (!held) begin
            count    <= REF_COUNT_ZERO;
            accepted <= 1'b0;
        end else if (ref_rise && !accepted) begin
            if (count == REF_COUNT_WIDTH'(CYCLES - 1)) begin
                accepted <= 1'b1;
            end else begin
                count <= count + REF_COUNT_ONE;
            end
        end
    end
endmodule

// [verilog/serial_pin_mux_pkg.sv]
/*
 * constants and types for the serial data port pin function multiplexer.
 * assumes one 25 mhz system clock; the reference clock arrives as a level input.
 */
package serial_pin_mux_pkg;
    // =========================================================
    // function codes
    // =========================================================
    typedef enum logic [1:0] {
        fn_gpio    = 2'h0,
        fn_uart    = 2'h1,
        fn_capture = 2'h2
    } pin_function_type;

    localparam int               FUNC_WIDTH       = 2;
    localparam logic [1:0]       FUNC_RESET       = 2'h0;
    localparam int               RESET_REF_CYCLES = 3;
    localparam int               REF_COUNT_WIDTH  = 2;
    localparam logic [1:0]       REF_COUNT_ZERO   = 2'h0;
    localparam logic [1:0]       REF_COUNT_ONE    = 2'h1;
    localparam logic             PIN_DRIVE        = 1'b0;
    localparam logic             PIN_RELEASE      = 1'b1;
endpackage

// [verilog/serial_port_pin_function_mux.sv]
/*
 * pin function multiplexer for transmit, receive and request-to-send pins.
 * assumes internal uart, capture timer, tap and reset logic sit on the inside,
 * and software function selects are plain inputs; everything is clk-synchronous.
 */
`timescale 1ns/1ps
// Functional notes
// - normal transmit function drives uart serial data on pin one
// - pin one is gpio when transmit is not chosen
// - pins are inputs in reset and follow the function selects and gpio_dir afterwards
// - alternate pin one drives tap data out only in shift states
// - dedicated data-out pin is cut off while alternate is enabled
// - normal receive function feeds pin two into uart receiver
// - capture choice routes pin two to autobaud capture channel
// - pins two and three are gpio when no function chosen
// - alternate pin two feeds tap data in, sampled on system clock
// - dedicated data-in pin is cut off while alternate is enabled
// - normal flow control puts uart request-to-send on pin three
// - capture choice routes pin three to second capture channel
// - alternate pin three is an active-low reset request
// - reset request counts only after three reference clock cycles low
// - dedicated reset pin ignored while alternate reset is enabled
module serial_port_pin_function_mux
    import serial_pin_mux_pkg::*;
#(
    parameter int RESET_CYCLES = RESET_REF_CYCLES
) (
    input  wire logic                          clk,                       // system clock
    input  wire logic                          reset,                     // async reset, active high
    input  wire logic                          function_group_select,     // low normal, high alternate
    input  wire serial_pin_mux_pkg::pin_function_type tx_function,        // pin one function
    input  wire serial_pin_mux_pkg::pin_function_type rx_function,        // pin two function
    input  wire serial_pin_mux_pkg::pin_function_type rts_function,       // pin three function
    input  wire logic [2:0]                    gpio_out,                  // gpio output data
    input  wire logic [2:0]                    gpio_dir,                  // gpio direction, 1 output
    output logic [2:0]                         gpio_in,                   // gpio input data
    input  wire logic                          uart_tx_data,              // uart serial output
    output logic                               uart_rx_data,              // uart serial input
    input  wire logic                          uart_rts,                  // uart request-to-send
    output logic                               autobaud_capture_input,    // capture channel one
    output logic                               second_capture_input,      // capture channel two
    input  wire logic                          tap_data_out,              // tap serial output
    input  wire logic                          tap_shift_state,           // tap in shift-ir or shift-dr
    output logic                               tap_data_in,               // data into tap
    output logic                               tap_data_out_pin,          // dedicated data-out pin level
    output logic                               tap_data_out_pin_oe_n,     // dedicated data-out enable, low drives
    input  wire logic                          tap_data_in_pin,           // dedicated data-in pin
    input  wire logic                          reset_in_pin_n,            // dedicated reset pin, low active
    input  wire logic                          low_freq_reference_clock,  // reference clock level
    output logic                               internal_reset,            // reset request to chip
    input  wire logic [2:0]                    pin_in,                    // pad input levels
    output logic [2:0]                         pin_out,                   // pad output levels
    output logic [2:0]                         pin_oe_n                   // pad enables, low drives
);
    // =========================================================
    // selection
    // =========================================================
    logic alt_accepted;
    logic next_uart_rx;
    logic next_tap_in;
    logic [2:0] next_out;
    logic [2:0] next_oe_n;

    wire alt = function_group_select;

    ref_low_counter #(.CYCLES(RESET_CYCLES)) reset_filter (
        .clk       (clk),
        .reset     (reset),
        .enable    (alt),
        .request_n (pin_in[2]),
        .ref_clock (low_freq_reference_clock),
        .accepted  (alt_accepted)
    );

    // =========================================================
    // pad drive
    // =========================================================
    always_comb begin
        next_out  = gpio_out;
        next_oe_n = ~gpio_dir;
        if (alt) begin
            next_out[0]  = tap_data_out;
            next_oe_n[0] = tap_shift_state ? PIN_DRIVE : PIN_RELEASE;
            next_out[1]  = 1'b0;
            next_oe_n[1] = PIN_RELEASE;
            next_out[2]  = 1'b0;
            next_oe_n[2] = PIN_RELEASE;
        end else begin
            if (tx_function == fn_uart) begin
                next_out[0]  = uart_tx_data;
                next_oe_n[0] = PIN_DRIVE;
            end
            if (rx_function != fn_gpio) begin
                next_out[1]  = 1'b0;
                next_oe_n[1] = PIN_RELEASE;
            end
            if (rts_function == fn_uart) begin
                next_out[2]  = uart_rts;
                next_oe_n[2] = PIN_DRIVE;
            end else if (rts_function == fn_capture) begin
                next_out[2]  = 1'b0;
                next_oe_n[2] = PIN_RELEASE;
            end
        end
    end

    // pads released in reset
    // released enables keep the pads from fighting the board until a function is chosen
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_oe_n <= {3{PIN_RELEASE}};
        end else begin
            pin_oe_n <= next_oe_n;
        end
    end

    // registered pad data
    // data is don't-care while released, so a low reset level is safe
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_out <= 3'h0;
        end else begin
            pin_out <= next_out;
        end
    end

    // =========================================================
    // inward routing
    // =========================================================
    always_comb begin
        next_uart_rx = (!alt && rx_function == fn_uart) ? pin_in[1] : 1'b1;
        next_tap_in  = alt ? pin_in[1] : tap_data_in_pin;
    end

    // receiver input register
    // idle high so a deselected receiver never sees a start bit
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            uart_rx_data <= 1'b1;
        end else begin
            uart_rx_data <= next_uart_rx;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            autobaud_capture_input <= 1'b1;
        end else begin
            autobaud_capture_input <= (!alt && rx_function == fn_capture) ? pin_in[1] : 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            second_capture_input <= 1'b1;
        end else begin
            second_capture_input <= (!alt && rts_function == fn_capture) ? pin_in[2] : 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tap_data_in <= 1'b1;
        end else begin
            tap_data_in <= next_tap_in;
        end
    end

    // gpio input sampling
    // pads are read in every function so software can always see the level
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            gpio_in <= 3'h0;
        end else begin
            gpio_in <= pin_in;
        end
    end

    // =========================================================
    // dedicated test pins
    // =========================================================

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tap_data_out_pin      <= 1'b0;
            tap_data_out_pin_oe_n <= PIN_RELEASE;
        end else begin
            tap_data_out_pin      <= tap_data_out;
            tap_data_out_pin_oe_n <= (!alt && tap_shift_state) ? PIN_DRIVE : PIN_RELEASE;
        end
    end

    // =========================================================
    // reset source
    // =========================================================
    // only one source at a time, so a floating dedicated pin cannot reset the chip while alternate is enabled
    // reset source select
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            internal_reset <= 1'b0;
        end else begin
            internal_reset <= alt ? alt_accepted : ~reset_in_pin_n;
        end
    end
endmodule
